// *** kbcpc_defs.svh ***
`ifndef KBCPC_DEFS_SVH
`define KBCPC_DEFS_SVH

// ----------------------------------------------------------------------
// Message layout
// ----------------------------------------------------------------------
`define KBCPC_MSG_WORDS      3'd5
`define KBCPC_HDR0_BYTE0     8'h00
`define KBCPC_HDR1_BYTE0     8'h08
`define KBCPC_OP_KEY_INPUT   8'h01
`define KBCPC_OP_LED_OUTPUT  8'h02
`define KBCPC_MSG_LENGTH     8'h14
`define KBCPC_KEY_DOWN       8'h01
`define KBCPC_KEY_UP         8'h00

// ----------------------------------------------------------------------
// Typematic parameter block
// ----------------------------------------------------------------------
`define KBCPC_PARAM_TYPE     16'h0004
`define KBCPC_PARAM_LENGTH   16'h0008
`define KBCPC_TM_ENABLE_ON   8'h01
`define KBCPC_RATE_LSB       0
`define KBCPC_RATE_MSB       4
`define KBCPC_DELAY_LSB      5
`define KBCPC_DELAY_MSB      6
`define KBCPC_LED_BITS       5
`define KBCPC_RST_ENABLE     1'b1
`define KBCPC_RST_RATE       5'h0b
`define KBCPC_RST_DELAY      2'h1
`define KBCPC_DELAY_P0       16'h09c4
`define KBCPC_DELAY_P1       16'h1388
`define KBCPC_DELAY_P2       16'h1d4c
`define KBCPC_DELAY_P3       16'h2710

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define KBCPC_REG_CHANNEL    4'h0
`define KBCPC_REG_STATUS     4'h4
`define KBCPC_REG_TYPEMATIC  4'h8
`define KBCPC_REG_LED        4'hc

`endif

// *** kbcpc_pkg.sv ***
package kbcpc_pkg;
  typedef enum logic [1:0] {
    KBCPC_RX_IDLE,
    KBCPC_RX_KEYMSG,
    KBCPC_RX_PARAM
  } kbcpc_rx_state_t;
endpackage

// *** kbcpc_rate_table.sv ***
`timescale 1ns/10ps
`include "kbcpc_defs.svh"

// Repeat period in tenths of a millisecond per rate code.
module kbcpc_rate_table (
  input  wire logic [4:0]  rate_code_i,
  output logic      [15:0] period_o
);
  always_comb begin
    unique case (rate_code_i)
      5'h00: period_o = 16'h014d; 5'h01: period_o = 16'h0176;
      5'h02: period_o = 16'h01a0; 5'h03: period_o = 16'h01ca;
      5'h04: period_o = 16'h01e3; 5'h05: period_o = 16'h021c;
      5'h06: period_o = 16'h0248; 5'h07: period_o = 16'h0271;
      5'h08: period_o = 16'h029b; 5'h09: period_o = 16'h02eb;
      5'h0a: period_o = 16'h0341; 5'h0b: period_o = 16'h0395;
      5'h0c: period_o = 16'h03e8; 5'h0d: period_o = 16'h043e;
      5'h0e: period_o = 16'h048a; 5'h0f: period_o = 16'h04e2;
      5'h10: period_o = 16'h0535; 5'h11: period_o = 16'h05d4;
      5'h12: period_o = 16'h0682; 5'h13: period_o = 16'h0710;
      5'h14: period_o = 16'h07d0; 5'h15: period_o = 16'h087d;
      5'h16: period_o = 16'h0915; 5'h17: period_o = 16'h09c4;
      5'h18: period_o = 16'h0a8f; 5'h19: period_o = 16'h0bd6;
      5'h1a: period_o = 16'h0d05; 5'h1b: period_o = 16'h0e4b;
      5'h1c: period_o = 16'h0fa0; 5'h1d: period_o = 16'h10fc;
      5'h1e: period_o = 16'h1297; default: period_o = 16'h1388;
    endcase
  end
endmodule // kbcpc_rate_table

// *** kbcpc_codec.sv ***
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "kbcpc_defs.svh"

// Notes on behaviour
// - Parameter block header: type 0004, length 0008.
// - Word 1: enable, rate, reserved, delay bytes.
// - Enable zero disables repeat, 01 enables.
// - One repeat rate for all keys.
// - Five-bit rate code, 30.0 down to 2.0.
// - Two-bit delay code, 0.25 to 1.00 seconds.
// - Reset default: enabled, 500 ms, 10.9 cps.
// - Reserved bytes ignored on receive, zero sent.
// - Only key input and LED output messages.
// - Key input opcode 01 in header byte one.
// - Five words: channel, opcode, stamp, sequences.
// - One message per key event, latest key; events arriving while a message is being sent are dropped.
// - Word 4: usage code byte 1, flag byte 3.
// - Press flag one on press, zero release.
// - LED output opcode 02, same header.
// - LED bit map in byte 0 of word 4.
// - Bits: num, caps, scroll, compose, kana.
// - LED map drives all attached keyboards.
// - Report phantom usage code on overflow.
module kbcpc_codec #(
  parameter int          KBD_COUNT     = 2,
  parameter int          CLK_HZ        = 50_000_000,
  parameter int          TICK_CYCLES   = CLK_HZ / 10_000,
  parameter logic [7:0]  PHANTOM_USAGE = 8'h01
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic [3:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [31:0]          reg_rdata_o,
  input  wire logic [31:0]          rx_word_i,
  input  wire logic                 rx_valid_i,
  input  wire logic                 rx_first_i,
  input  wire logic                 key_event_i,
  input  wire logic [7:0]           key_usage_i,
  input  wire logic                 key_down_i,
  input  wire logic                 key_overflow_i,
  output logic      [31:0]          tx_word_o,
  output logic                      tx_valid_o,
  output logic                      tx_first_o,
  output logic                      tx_busy_o,
  output logic      [KBD_COUNT*5-1:0] led_kbd_o,
  output logic                      repeat_o,
  output logic      [7:0]           repeat_usage_o
);
  import kbcpc_pkg::*;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [15:0]     chan_id_reg;
  logic [15:0]     tx_seq_reg;
  logic [15:0]     rx_seq_reg;
  logic [31:0]     stamp_reg;
  logic            tm_enable_reg;
  logic [4:0]      tm_rate_reg;
  logic [1:0]      tm_delay_reg;
  logic [4:0]      led_map_reg;
  logic [7:0]      discard_cnt_reg;
  kbcpc_rx_state_t rx_state_reg;
  logic [2:0]      rx_idx_reg;
  logic [7:0]      rx_op_reg;
  logic [2:0]      tx_idx_reg;
  logic [7:0]      tx_usage_reg;
  logic [7:0]      tx_flag_reg;
  logic [15:0]     tick_cnt_reg;
  logic [15:0]     rep_cnt_reg;
  logic            held_reg;
  logic            repeating_reg;
  logic [15:0]     rate_period;
  logic [15:0]     delay_period;
  logic            tick;

  kbcpc_rate_table u_rate (
    .rate_code_i (tm_rate_reg),
    .period_o    (rate_period)
  );

  // --------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      chan_id_reg <= 16'h0000;
      stamp_reg   <= 32'h0000_0000;
    end else if (reg_wr_i && reg_addr_i == `KBCPC_REG_CHANNEL) begin
      chan_id_reg <= reg_wdata_i[15:0];
      stamp_reg   <= {16'h0000, reg_wdata_i[31:16]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `KBCPC_REG_CHANNEL:   reg_rdata_o <= {16'h0000, chan_id_reg};
        `KBCPC_REG_STATUS:    reg_rdata_o <= {discard_cnt_reg, 6'h00,
                                              rx_state_reg, tx_seq_reg};
        `KBCPC_REG_TYPEMATIC: reg_rdata_o <= {24'h000000, tm_enable_reg,
                                              tm_delay_reg, tm_rate_reg};
        `KBCPC_REG_LED:       reg_rdata_o <= {rx_seq_reg, 11'h000,
                                              led_map_reg};
        default:              reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------
  // Receive parser
  // --------------------------------------------------------------------
  // Reserved bytes are never looked at, so future senders cannot upset us.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rx_state_reg <= KBCPC_RX_IDLE;
      rx_idx_reg   <= 3'd0;
      rx_op_reg    <= 8'h00;
    end else if (rx_valid_i) begin
      if (rx_first_i) begin
        rx_idx_reg <= 3'd1;
        if (rx_word_i == {`KBCPC_PARAM_LENGTH, `KBCPC_PARAM_TYPE}) begin
          rx_state_reg <= KBCPC_RX_PARAM;
        end else if (rx_word_i[7:0] == `KBCPC_HDR0_BYTE0) begin
          rx_state_reg <= KBCPC_RX_KEYMSG;
        end else begin
          rx_state_reg <= KBCPC_RX_IDLE;
        end
      end else if (rx_state_reg != KBCPC_RX_IDLE) begin
        if (rx_idx_reg == 3'd1) begin
          rx_op_reg <= rx_word_i[15:8];
        end
        if (rx_state_reg == KBCPC_RX_PARAM ||
            rx_idx_reg == `KBCPC_MSG_WORDS - 3'd1) begin
          rx_state_reg <= KBCPC_RX_IDLE;
        end
        rx_idx_reg <= rx_idx_reg + 3'd1;
      end
    end
  end

  // Typematic settings, reset to the pre-association defaults.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tm_enable_reg <= `KBCPC_RST_ENABLE;
      tm_rate_reg   <= `KBCPC_RST_RATE;
      tm_delay_reg  <= `KBCPC_RST_DELAY;
    end else if (rx_valid_i && !rx_first_i &&
                 rx_state_reg == KBCPC_RX_PARAM) begin
      // Unlisted enable values keep the old setting.
      if (rx_word_i[7:0] == 8'h00) begin
        tm_enable_reg <= 1'b0;
      end else if (rx_word_i[7:0] == `KBCPC_TM_ENABLE_ON) begin
        tm_enable_reg <= 1'b1;
      end
      tm_rate_reg  <= rx_word_i[8+`KBCPC_RATE_MSB:8+`KBCPC_RATE_LSB];
      tm_delay_reg <= rx_word_i[24+`KBCPC_DELAY_MSB:24+`KBCPC_DELAY_LSB];
    end
  end

  // LED message word 4 and sequence number; others are discarded.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      led_map_reg     <= 5'h00;
      rx_seq_reg      <= 16'h0000;
      discard_cnt_reg <= 8'h00;
    end else if (rx_valid_i && !rx_first_i &&
                 rx_state_reg == KBCPC_RX_KEYMSG) begin
      if (rx_idx_reg == 3'd4 &&
          rx_op_reg == `KBCPC_OP_LED_OUTPUT) begin
        led_map_reg <= rx_word_i[`KBCPC_LED_BITS-1:0];
        rx_seq_reg  <= rx_seq_reg + 16'h0001;
      end else if (rx_idx_reg == 3'd4) begin
        discard_cnt_reg <= discard_cnt_reg + 8'h01;
      end
    end
  end

  // One map fans out to every keyboard so all indicators agree.
  genvar g;
  generate
    for (g = 0; g < KBD_COUNT; g++) begin : g_led
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          led_kbd_o[g*5 +: 5] <= 5'h00;
        end else begin
          led_kbd_o[g*5 +: 5] <= led_map_reg;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Key input transmitter
  // --------------------------------------------------------------------
  // Events arriving while busy are dropped; the source must wait.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_idx_reg   <= 3'd0;
      tx_busy_o    <= 1'b0;
      tx_usage_reg <= 8'h00;
      tx_flag_reg  <= 8'h00;
      tx_seq_reg   <= 16'h0000;
    end else if (!tx_busy_o && key_event_i) begin
      tx_busy_o    <= 1'b1;
      tx_idx_reg   <= 3'd0;
      tx_usage_reg <= key_overflow_i ? PHANTOM_USAGE : key_usage_i;
      tx_flag_reg  <= key_down_i ? `KBCPC_KEY_DOWN : `KBCPC_KEY_UP;
    end else if (tx_busy_o) begin
      if (tx_idx_reg == `KBCPC_MSG_WORDS - 3'd1) begin
        tx_busy_o  <= 1'b0;
        tx_seq_reg <= tx_seq_reg + 16'h0001;
      end
      tx_idx_reg <= tx_idx_reg + 3'd1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_word_o  <= 32'h0000_0000;
      tx_valid_o <= 1'b0;
      tx_first_o <= 1'b0;
    end else begin
      tx_valid_o <= tx_busy_o;
      tx_first_o <= tx_busy_o && tx_idx_reg == 3'd0;
      unique case (tx_idx_reg)
        3'd0: tx_word_o <= {chan_id_reg, 8'h00, `KBCPC_HDR0_BYTE0};
        3'd1: tx_word_o <= {8'h00, `KBCPC_MSG_LENGTH,
                            `KBCPC_OP_KEY_INPUT, `KBCPC_HDR1_BYTE0};
        3'd2: tx_word_o <= stamp_reg;
        3'd3: tx_word_o <= {rx_seq_reg, tx_seq_reg};
        default: tx_word_o <= {tx_flag_reg, 8'h00,
                               tx_usage_reg, 8'h00};
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Auto-repeat
  // --------------------------------------------------------------------
  // A table keeps each delay exact in tenths of a millisecond.
  always_comb begin
    unique case (tm_delay_reg)
      2'h0: delay_period = `KBCPC_DELAY_P0;
      2'h1: delay_period = `KBCPC_DELAY_P1;
      2'h2: delay_period = `KBCPC_DELAY_P2;
      2'h3: delay_period = `KBCPC_DELAY_P3;
    endcase
  end
  assign tick = tick_cnt_reg == 16'(TICK_CYCLES - 1);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // A single counter serves all keys, so the rate is shared.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      held_reg       <= 1'b0;
      repeating_reg  <= 1'b0;
      rep_cnt_reg    <= 16'h0000;
      repeat_o       <= 1'b0;
      repeat_usage_o <= 8'h00;
    end else begin
      repeat_o <= 1'b0;
      if (key_event_i) begin
        held_reg       <= key_down_i && !key_overflow_i;
        repeating_reg  <= 1'b0;
        rep_cnt_reg    <= 16'h0000;
        repeat_usage_o <= key_usage_i;
      end else if (held_reg && tm_enable_reg && tick) begin
        if (rep_cnt_reg + 16'h0001 >=
            (repeating_reg ? rate_period : delay_period)) begin
          rep_cnt_reg   <= 16'h0000;
          repeating_reg <= 1'b1;
          repeat_o      <= 1'b1;
        end else begin
          rep_cnt_reg <= rep_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  tm_reset_val_a: assert property ($rose(rst_n_i) |->
    tm_enable_reg && tm_rate_reg == 5'h0b && tm_delay_reg == 2'h1)
    else $error("typematic defaults wrong after reset");
  param_enable_off_a: assert property (rx_valid_i && !rx_first_i &&
    rx_state_reg == KBCPC_RX_PARAM && rx_word_i[7:0] == 8'h00 |=>
    !tm_enable_reg)
    else $error("enable byte zero did not disable repeat");
  param_rate_load_a: assert property (rx_valid_i && !rx_first_i &&
    rx_state_reg == KBCPC_RX_PARAM |=>
    tm_rate_reg == $past(rx_word_i[12:8]) &&
    tm_delay_reg == $past(rx_word_i[30:29]))
    else $error("rate or delay field not taken from byte 1 or 3");
  tx_header_op_a: assert property (tx_valid_o && tx_first_o |=>
    tx_valid_o && tx_word_o[15:8] == 8'h01 && tx_word_o[7:0] == 8'h08)
    else $error("key message opcode word wrong");
  tx_five_words_a: assert property ($rose(tx_valid_o) |->
    tx_valid_o [*5] ##1 !tx_valid_o)
    else $error("key message not five words");
  tx_flag_press_a: assert property (!tx_busy_o && key_event_i &&
    key_down_i |-> ##6 tx_word_o[31:24] == 8'h01)
    else $error("press flag not one");
  tx_phantom_a: assert property (!tx_busy_o && key_event_i &&
    key_overflow_i |-> ##6 tx_word_o[15:8] == PHANTOM_USAGE)
    else $error("phantom usage not reported");
  led_fanout_a: assert property (1 |=>
    led_kbd_o == {KBD_COUNT{$past(led_map_reg)}})
    else $error("keyboard LEDs do not follow map");
  unknown_op_a: assert property (rx_valid_i && !rx_first_i &&
    rx_state_reg == KBCPC_RX_KEYMSG && rx_idx_reg == 3'd4 &&
    rx_op_reg != 8'h02 |=> $stable(led_map_reg))
    else $error("unknown opcode changed LED map");
  repeat_off_a: assert property (!tm_enable_reg |=> !repeat_o)
    else $error("repeat while disabled");

endmodule // kbcpc_codec

// *** kbcpc_host_model.sv ***
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Remote host end of the keyboard channel
// ---------------------------------------------------------------
module kbcpc_host_model (
  input  wire logic        clock_i,
  output logic      [31:0] rx_word_o,
  output logic             rx_valid_o,
  output logic             rx_first_o
);
  initial begin
    rx_word_o  = 32'h0000_0000;
    rx_valid_o = 1'b0;
    rx_first_o = 1'b0;
  end

  task automatic put(input logic [31:0] w, input logic f);
    @(posedge clock_i);
    rx_word_o  <= w;
    rx_valid_o <= 1'b1;
    rx_first_o <= f;
  endtask

  // Idle words are inverted so a receiver sampling outside a frame
  // never sees the last word again.
  task automatic idle();
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_first_o <= 1'b0;
    rx_word_o  <= ~rx_word_o;
  endtask

  task automatic send_msg(input logic [7:0] op, input logic [31:0] w4);
    put(32'h0a5c_0000, 1'b1);
    put({8'h00, 8'h14, op, 8'h08}, 1'b0);
    put(32'h0000_1234, 1'b0);
    put(32'h0001_0001, 1'b0);
    put(w4, 1'b0);
    idle();
  endtask

  // The reserved byte carries junk on purpose.
  task automatic send_param(input logic [7:0] en, input logic [4:0] rt,
                            input logic [1:0] dl);
    put(32'h0008_0004, 1'b1);
    put({1'b0, dl, 5'h00, 8'hff, 3'h0, rt, en}, 1'b0);
    idle();
  endtask
endmodule // kbcpc_host_model

// *** kbcpc_codec_bench.sv ***
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Bench for the keyboard channel codec
// ---------------------------------------------------------------
module kbcpc_codec_bench;
  localparam logic [7:0]  PH = 8'h01;
  localparam logic [17:0] ROWS [4] = '{{8'h39, 2'b10, 8'h39},
    {8'he1, 2'b10, 8'he1}, {8'h39, 2'b00, 8'h39}, {8'h04, 2'b11, PH}};
  localparam logic [4:0]  RATES [4] = '{5'h00, 5'h1f, 5'h0b, 5'h17};
  localparam logic [7:0]  OPS [4] = '{8'h00, 8'h01, 8'h03, 8'hff};
  logic        clock_i;
  logic        rst_n_i;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [31:0] rx_word;
  logic        rx_valid;
  logic        rx_first;
  logic        kev;
  logic [7:0]  kuse;
  logic        kdown;
  logic        kovf;
  logic [31:0] tx_word;
  logic        tx_valid;
  logic        tx_first;
  logic        tx_busy;
  logic [9:0]  led;
  logic        rep;
  logic [7:0]  rep_use;
  logic [31:0] v;
  logic [7:0]  m;
  logic [31:0] cap [5];
  time         tev;
  int          num_errors;
  int          n_compared;
  int          n;
  int          i;

  kbcpc_codec #(.TICK_CYCLES(2), .PHANTOM_USAGE(PH)) u_kbcpc_codec (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .rx_word_i(rx_word), .rx_valid_i(rx_valid),
    .rx_first_i(rx_first), .key_event_i(kev), .key_usage_i(kuse),
    .key_down_i(kdown), .key_overflow_i(kovf), .tx_word_o(tx_word),
    .tx_valid_o(tx_valid), .tx_first_o(tx_first), .tx_busy_o(tx_busy),
    .led_kbd_o(led), .repeat_o(rep), .repeat_usage_o(rep_use));

  kbcpc_host_model u_kbcpc_host_model (
    .clock_i(clock_i), .rx_word_o(rx_word), .rx_valid_o(rx_valid),
    .rx_first_o(rx_first));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic send_key(input logic [7:0] u, input logic d, input logic o);
    int k;
    @(posedge clock_i);
    kuse  <= u;
    kdown <= d;
    kovf  <= o;
    kev   <= 1'b1;
    tev = $time;
    @(posedge clock_i);
    kev <= 1'b0;
    #1;
    for (k = 0; k < 8 && tx_first !== 1'b1; k++) begin
      @(posedge clock_i);
      #1;
    end
    if (tx_first !== 1'b1) begin
      chk(32'h0, 32'h1);
      results();
    end
    chk(tx_busy, 1'b1);
    for (k = 0; k < 5; k++) begin
      chk(tx_valid, 1'b1);
      cap[k] = tx_word;
      @(posedge clock_i);
      #1;
    end
    chk(tx_valid, 1'b0);
  endtask

  // Counts cycles until a repeat pulse, giving up at the limit.
  task automatic wait_rep(input int lim);
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (rep !== 1'b1 && n < lim);
  endtask

  task automatic settle();
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  initial begin
    rst_n_i = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    kev = 1'b0;
    kuse = 8'h00;
    kdown = 1'b0;
    kovf = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk({tx_valid, tx_busy, rep, led}, 32'h0);
    rd_reg(4'h8, v);
    chk(v, 32'h0000_00ab);
    rd_reg(4'h2, v);
    chk(v, 32'h0);
    wr_reg(4'h8, 32'h0);
    rd_reg(4'h8, v);
    chk(v, 32'h0000_00ab);
    wr_reg(4'h0, 32'h5678_0a5c);
    rd_reg(4'h0, v);
    chk(v, 32'h0000_0a5c);
    for (i = 0; i < 4; i++) begin
      send_key(ROWS[i][17:10], ROWS[i][9], ROWS[i][8]);
      chk(cap[0], 32'h0a5c_0000);
      chk(cap[1], 32'h0014_0108);
      chk(cap[2][15:0], 32'h5678);
      chk(cap[3], 32'(i));
      chk(cap[4], {7'h0, ROWS[i][9], 8'h00, ROWS[i][7:0], 8'h00});
    end
    fork
      send_key(8'h1e, 1'b1, 1'b0);
      begin
        repeat (3) @(posedge clock_i);
        kev <= 1'b1;
        @(posedge clock_i);
        kev <= 1'b0;
      end
    join
    chk(cap[4][15:8], 8'h1e);
    n = 0;
    repeat (10) begin
      @(posedge clock_i);
      #1;
      n += int'(tx_first === 1'b1);
    end
    chk(n, 0);
    for (i = 0; i < 6; i++) begin
      m = (i < 5) ? (8'h01 << i) : 8'hff;
      u_kbcpc_host_model.send_msg(8'h02, {24'hffffff, m});
      settle();
      chk(led, {2{m[4:0]}});
    end
    for (i = 0; i < 4; i++) begin
      u_kbcpc_host_model.send_msg(OPS[i], 32'h0);
      settle();
    end
    chk(led, 10'h3ff);
    rd_reg(4'h4, v);
    chk(v[31:24], 8'h04);
    rd_reg(4'hc, v);
    chk(v & 32'hffff_001f, 32'h0006_001f);
    for (i = 0; i < 4; i++) begin
      u_kbcpc_host_model.send_param(8'h01, RATES[i], 2'(i));
      rd_reg(4'h8, v);
      chk(v, {24'h0, 1'b1, 2'(i), RATES[i]});
    end
    u_kbcpc_host_model.send_param(8'h00, 5'h0b, 2'h1);
    rd_reg(4'h8, v);
    chk(v, 32'h2b);
    u_kbcpc_host_model.send_param(8'h07, 5'h0b, 2'h1);
    rd_reg(4'h8, v);
    chk(v, 32'h2b);
    u_kbcpc_host_model.send_param(8'h01, 5'h00, 2'h0);
    send_key(8'h04, 1'b1, 1'b0);
    wait_rep(7000);
    if (n >= 7000) begin
      chk(32'h0, 32'h1);
      results();
    end
    chk((($time - tev) / 20) inside {[4990:5030]}, 1'b1);
    chk(rep_use, 8'h04);
    wait_rep(1000);
    chk(n inside {[650:690]}, 1'b1);
    send_key(8'h04, 1'b0, 1'b0);
    wait_rep(6000);
    chk(n, 6000);
    u_kbcpc_host_model.send_param(8'h01, 5'h0b, 2'h1);
    send_key(8'h06, 1'b1, 1'b0);
    wait_rep(11000);
    chk((($time - tev) / 20) inside {[9990:10030]}, 1'b1);
    chk(rep_use, 8'h06);
    u_kbcpc_host_model.send_param(8'h00, 5'h00, 2'h0);
    send_key(8'h05, 1'b1, 1'b0);
    wait_rep(6000);
    chk(n, 6000);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk({tx_valid, tx_busy, rep, led}, 32'h0);
    rd_reg(4'h8, v);
    chk(v, 32'h0000_00ab);
    results();
  end
endmodule // kbcpc_codec_bench
